// File: core/aas_top.sv
// Aux converter control and 3-wire serial readout, top level.
`timescale 1ns/1ps

// Functional notes
// - Conversion clock is system clock divided by two to the divider field, reset 0.
// - Results appear on the serial output only with output mode set; reset clear.
// - Serial output is high impedance only when idle or locked; it is driven while converting, holding a result or reading out.
// - Writing start drives the serial output high to show busy.
// - After all averaging the result is stored and the output driven low as ready.
// - With output mode set, readout starts at the next select/wake falling edge.
// - Result shifts out MSB first, changing on each serial clock falling edge.
// - Frame is 16 bits; the last result bit repeats for the final six.
// - Select/wake going high at the end of a readout returns the serial output to high impedance.
// - No new conversion starts while an unread result is held.
// - Start over an unread mode-0 result disables output until start 0 is written.
// - Back-to-back: select fall shifts old result, select rise loads new command.
// - 16-bit instructions are accepted at any time and update addressed settings.
// - Instructions to address 1111 change nothing.
// - Start clears itself at completion and is ignored during a conversion.
// - Each conversion takes twelve conversion-clock edges.
// - Averaging codes give 1 to 32 conversions, codes 11x give 32.
// - A two-bit field selects one of four converter inputs.
module aas_top
	import aas_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// Serial interface pins
	input  wire logic       cs_wake_n_i,
	input  wire logic       sclk_i,
	input  wire logic       din_i,
	output logic            dout_o,
	output logic            dout_oe_n_o,
	// Converter front end
	input  wire logic [9:0] sample_i,
	output logic [1:0]      input_select_o,
	output logic            converter_reference_select_o,
	// Status
	output logic            convert_start_o
);

	aas_conv_if cv ();

	logic [2:0]    pins;
	logic [2:0]    sync_a;
	logic [2:0]    sync_b;
	logic [2:0]    sync_c;
	logic          cs_fall;
	logic          cs_rise;
	logic          sclk_fall;
	logic          sclk_rise;
	logic          cmd_valid;
	logic [15:0]   cmd_word;
	logic          cmd_hit;
	logic          cmd_start;

	aas_state_type state, next_state;
	logic [10:1]   cfg, next_cfg;
	logic [9:0]    out_reg, next_out_reg;
	logic [3:0]    bit_idx, next_bit_idx;
	logic          start_req, next_start_req;
	logic          dout, next_dout;
	logic          oe_n, next_oe_n;

	assign pins = {cs_wake_n_i, sclk_i, din_i};

	// Pins are asynchronous; the third stage exists only for edge detection.
	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_sync
			always_ff @(posedge core_clk_i)
			begin
				if (srst_i)
				begin
					sync_a[g] <= 1'b1;
					sync_b[g] <= 1'b1;
					sync_c[g] <= 1'b1;
				end
				else
				begin
					sync_a[g] <= pins[g];
					sync_b[g] <= sync_a[g];
					sync_c[g] <= sync_b[g];
				end
			end
		end
	endgenerate

	assign cs_fall   = sync_c[PIN_CS] & ~sync_b[PIN_CS];
	assign cs_rise   = ~sync_c[PIN_CS] & sync_b[PIN_CS];
	assign sclk_fall = sync_c[PIN_SCLK] & ~sync_b[PIN_SCLK];
	assign sclk_rise = ~sync_c[PIN_SCLK] & sync_b[PIN_SCLK];

	aas_sin u_sin (
		.core_clk_i  (core_clk_i),
		.srst_i      (srst_i),
		.sclk_rise_i (sclk_rise),
		.cs_fall_i   (cs_fall),
		.cs_rise_i   (cs_rise),
		.cs_low_i    (~sync_b[PIN_CS]),
		.din_i       (sync_b[PIN_DIN]),
		.cmd_valid_o (cmd_valid),
		.cmd_word_o  (cmd_word)
	);

	aas_conv u_conv (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.sample_i   (sample_i),
		.cv         (cv.conv)
	);

	// Address 1111 never matches a register, so an all-ones frame is harmless.
	function automatic logic addr_hit(input logic [15:0] word);
		if (word[15:ADDR_LSB] == VOID_ADDR)
			addr_hit = 1'b0;
		else if (word[15:ADDR_LSB] == AUX_CFG_ADDR)
			addr_hit = 1'b1;
		else
			addr_hit = 1'b0;
	endfunction

	assign cmd_hit   = cmd_valid && addr_hit(cmd_word);
	assign cmd_start = cmd_hit && cmd_word[START_POS];

	always_comb
	begin
		next_state     = state;
		next_cfg       = cfg;
		next_out_reg   = out_reg;
		next_bit_idx   = bit_idx;
		next_start_req = 1'b0;
		if (cmd_hit)
			next_cfg = cmd_word[CFG_MSB:REF_POS];
		case (state)
			ST_IDLE:
			begin
				// Start is issued a cycle later so the new divider and averaging apply.
				if (cmd_start)
				begin
					next_state     = ST_BUSY;
					next_start_req = 1'b1;
				end
			end
			ST_BUSY:
			begin
				// Start writes here are ignored; the bit clears itself on completion.
				if (cv.done)
				begin
					next_state   = ST_READY;
					next_out_reg = cv.result;
				end
			end
			ST_READY:
			begin
				if (cs_fall && cfg[OUTEN_POS])
				begin
					next_state   = ST_SHIFT;
					next_bit_idx = 4'h0;
				end
				else if (cmd_start)
					next_state = ST_LOCKED;
			end
			ST_SHIFT:
			begin
				if (cs_rise)
					next_state = ST_IDLE;
				else if (sclk_fall && (bit_idx != LAST_BIT_IDX))
					next_bit_idx = bit_idx + 4'h1;
			end
			ST_LOCKED:
			begin
				if (cmd_hit && !cmd_word[START_POS])
					next_state = ST_IDLE;
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	// Pin drive follows the next state so the pin and the state change together.
	always_comb
	begin
		next_dout = 1'b0;
		next_oe_n = 1'b1;
		case (next_state)
			ST_BUSY:
			begin
				next_oe_n = 1'b0;
				next_dout = 1'b1;
			end
			ST_READY:
				next_oe_n = 1'b0;
			ST_SHIFT:
			begin
				next_oe_n = 1'b0;
				if (next_bit_idx < TAIL_BIT_IDX)
					next_dout = next_out_reg[4'h9 - next_bit_idx];
				else
					next_dout = next_out_reg[0];
			end
			default:
				next_oe_n = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state     <= ST_IDLE;
			cfg       <= CFG_RESET;
			out_reg   <= 10'h000;
			bit_idx   <= 4'h0;
			start_req <= 1'b0;
			dout      <= 1'b0;
			oe_n      <= 1'b1;
		end
		else
		begin
			state     <= next_state;
			cfg       <= next_cfg;
			out_reg   <= next_out_reg;
			bit_idx   <= next_bit_idx;
			start_req <= next_start_req;
			dout      <= next_dout;
			oe_n      <= next_oe_n;
		end
	end

	assign cv.start                     = start_req;
	assign cv.div_sel                   = cfg[DIV_LSB+2:DIV_LSB];
	assign cv.avg_sel                   = cfg[AVG_LSB+2:AVG_LSB];
	assign input_select_o               = cfg[INSEL_LSB+1:INSEL_LSB];
	assign converter_reference_select_o = cfg[REF_POS];
	assign convert_start_o              = (state == ST_BUSY);
	assign dout_o                       = dout;
	assign dout_oe_n_o                  = oe_n;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	property p_idle_hiz;
		(state == ST_IDLE) || (state == ST_LOCKED) |-> dout_oe_n_o;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while idle");

	property p_start_busy;
		(state == ST_IDLE) && cmd_start |=> !dout_oe_n_o && dout_o ##1 cv.busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not show busy high");

	property p_done_ready;
		(state == ST_BUSY) && cv.done |=> !dout_oe_n_o && !dout_o && (out_reg == $past(cv.result));
	endproperty
	a_done_ready: assert property (p_done_ready) else $error("result not loaded with ready low");

	property p_mode0_hold;
		(state == ST_READY) && cs_fall && !cfg[OUTEN_POS] |=> (state == ST_READY);
	endproperty
	a_mode0_hold: assert property (p_mode0_hold) else $error("result shifted with output mode clear");

	property p_msb_first;
		(state == ST_READY) && cs_fall && cfg[OUTEN_POS] |=> !dout_oe_n_o && (dout_o == out_reg[9]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("readout did not start with MSB");

	property p_step;
		(state == ST_SHIFT) && sclk_fall && !cs_rise && (bit_idx < 4'h9) |=> (dout_o == out_reg[4'h9 - bit_idx]);
	endproperty
	a_step: assert property (p_step) else $error("wrong bit after serial clock fall");

	property p_tail;
		(state == ST_SHIFT) && (bit_idx >= TAIL_BIT_IDX) |-> (dout_o == out_reg[0]);
	endproperty
	a_tail: assert property (p_tail) else $error("tail bits do not repeat last bit");

	property p_release;
		(state == ST_SHIFT) && cs_rise |=> dout_oe_n_o && (state == ST_IDLE);
	endproperty
	a_release: assert property (p_release) else $error("output kept driven after select high");

	property p_no_restart;
		(state == ST_READY) || (state == ST_LOCKED) |-> !cv.start;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("conversion started over held result");

	property p_lock;
		(state == ST_READY) && cmd_start && !cs_fall |=> (state == ST_LOCKED) && dout_oe_n_o;
	endproperty
	a_lock: assert property (p_lock) else $error("repeated start did not disable output");

	property p_void;
		cmd_valid && (cmd_word[15:ADDR_LSB] == VOID_ADDR) |=> $stable(cfg);
	endproperty
	a_void: assert property (p_void) else $error("all-ones address changed settings");

	property p_busy_ignore;
		(state == ST_BUSY) && cmd_start && !cv.done |=> (state == ST_BUSY) && !cv.start;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("start accepted during conversion");

endmodule // aas_top

// File: core/aas_pkg.sv
// Constants, field layout and state types for the aux converter readout block.
package aas_pkg;

	// Serial frame and result geometry.
	localparam int          FRAME_BITS    = 16;
	localparam int          RESULT_BITS   = 10;
	localparam logic [3:0]  LAST_BIT_IDX  = 4'hf;
	localparam logic [3:0]  TAIL_BIT_IDX  = 4'ha;
	localparam logic [4:0]  FRAME_COUNT   = 5'h10;

	// Instruction word: address in the top nibble, configuration below.
	localparam int          ADDR_LSB      = 12;
	localparam logic [3:0]  AUX_CFG_ADDR  = 4'h0;
	localparam logic [3:0]  VOID_ADDR     = 4'hf;

	// Configuration field positions inside the instruction word.
	localparam int          START_POS     = 0;
	localparam int          REF_POS       = 1;
	localparam int          INSEL_LSB     = 2;
	localparam int          AVG_LSB       = 4;
	localparam int          DIV_LSB       = 7;
	localparam int          OUTEN_POS     = 10;
	localparam int          CFG_MSB       = 10;
	localparam logic [10:1] CFG_RESET     = 10'h000;

	// One conversion spans twelve conversion-clock edges.
	localparam logic [3:0]  EDGES_PER_CONV = 4'hc;
	localparam logic [2:0]  AVG_LOG2_MAX   = 3'h5;

	// Synchroniser lanes for the serial pins.
	localparam int          PIN_DIN       = 0;
	localparam int          PIN_SCLK      = 1;
	localparam int          PIN_CS        = 2;

	typedef enum {ST_IDLE, ST_BUSY, ST_READY, ST_SHIFT, ST_LOCKED} aas_state_type;

	// Averaging code to log2 of the number of conversions; codes 11x saturate.
	function automatic logic [2:0] avg_log2(input logic [2:0] code);
		avg_log2 = (code > AVG_LOG2_MAX) ? AVG_LOG2_MAX : code;
	endfunction

endpackage

// File: core/aas_conv_if.sv
// Handshake between the readout controller and the conversion sequencer.
`timescale 1ns/1ps
interface aas_conv_if;
	logic       start;
	logic [2:0] div_sel;
	logic [2:0] avg_sel;
	logic       busy;
	logic       done;
	logic [9:0] result;

	modport ctrl (output start, output div_sel, output avg_sel,
		input busy, input done, input result);
	modport conv (input start, input div_sel, input avg_sel,
		output busy, output done, output result);
endinterface

// File: core/aas_conv.sv
// Conversion clock divider and averaging conversion sequencer.
`timescale 1ns/1ps
module aas_conv
	import aas_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// Converter sample
	input  wire logic [9:0] sample_i,
	// Controller side
	aas_conv_if.conv        cv
);

	logic [6:0]  div_cnt, next_div_cnt;
	logic [3:0]  edge_cnt, next_edge_cnt;
	logic [4:0]  avg_cnt, next_avg_cnt;
	logic [14:0] acc, next_acc;
	logic [2:0]  div_lat, next_div_lat;
	logic [2:0]  avg_lat, next_avg_lat;
	logic        busy, next_busy;
	logic        done, next_done;
	logic [9:0]  result, next_result;
	logic        tick;
	logic [6:0]  div_limit;
	logic [4:0]  avg_last;

	assign div_limit = 7'((8'h01 << div_lat) - 8'h01);
	assign tick      = busy && (div_cnt == div_limit);
	assign avg_last  = 5'((6'h01 << avg_log2(avg_lat)) - 6'h01);

	always_comb
	begin
		next_div_cnt  = div_cnt;
		next_edge_cnt = edge_cnt;
		next_avg_cnt  = avg_cnt;
		next_acc      = acc;
		next_div_lat  = div_lat;
		next_avg_lat  = avg_lat;
		next_busy     = busy;
		next_done     = 1'b0;
		next_result   = result;
		if (cv.start && !busy)
		begin
			// Settings are frozen for the whole conversion so late writes cannot skew it.
			next_busy     = 1'b1;
			next_div_lat  = cv.div_sel;
			next_avg_lat  = cv.avg_sel;
			next_div_cnt  = 7'h00;
			next_edge_cnt = 4'h0;
			next_avg_cnt  = 5'h00;
			next_acc      = 15'h0000;
		end
		else if (busy)
		begin
			next_div_cnt = tick ? 7'h00 : div_cnt + 7'h01;
			if (tick)
			begin
				if (edge_cnt == 4'h0)
					next_acc = acc + 15'(sample_i);
				if (edge_cnt == EDGES_PER_CONV - 4'h1)
				begin
					next_edge_cnt = 4'h0;
					next_avg_cnt  = avg_cnt + 5'h01;
					if (avg_cnt == avg_last)
					begin
						next_busy   = 1'b0;
						next_done   = 1'b1;
						next_result = 10'(acc >> avg_log2(avg_lat));
					end
				end
				else
					next_edge_cnt = edge_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			div_cnt  <= 7'h00;
			edge_cnt <= 4'h0;
			avg_cnt  <= 5'h00;
			acc      <= 15'h0000;
			div_lat  <= 3'h0;
			avg_lat  <= 3'h0;
			busy     <= 1'b0;
			done     <= 1'b0;
			result   <= 10'h000;
		end
		else
		begin
			div_cnt  <= next_div_cnt;
			edge_cnt <= next_edge_cnt;
			avg_cnt  <= next_avg_cnt;
			acc      <= next_acc;
			div_lat  <= next_div_lat;
			avg_lat  <= next_avg_lat;
			busy     <= next_busy;
			done     <= next_done;
			result   <= next_result;
		end
	end

	assign cv.busy   = busy;
	assign cv.done   = done;
	assign cv.result = result;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	property p_div_one;
		busy && $past(busy) && (div_lat == 3'h0) |-> tick;
	endproperty
	a_div_one: assert property (p_div_one) else $error("divide by one did not tick each clock");

	property p_edge_wrap;
		tick && (edge_cnt == 4'hb) |=> (edge_cnt == 4'h0);
	endproperty
	a_edge_wrap: assert property (p_edge_wrap) else $error("conversion did not end at edge twelve");

endmodule // aas_conv

// File: core/aas_sin.sv
// Serial instruction receiver on the select/wake framed input.
`timescale 1ns/1ps
module aas_sin
	import aas_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	// Synchronised pin events
	input  wire logic        sclk_rise_i,
	input  wire logic        cs_fall_i,
	input  wire logic        cs_rise_i,
	input  wire logic        cs_low_i,
	input  wire logic        din_i,
	// Received instruction
	output logic             cmd_valid_o,
	output logic [15:0]      cmd_word_o
);

	logic [15:0] shreg, next_shreg;
	logic [4:0]  cnt, next_cnt;
	logic        valid, next_valid;
	logic [15:0] word, next_word;

	always_comb
	begin
		next_shreg = shreg;
		next_cnt   = cnt;
		next_valid = 1'b0;
		next_word  = word;
		if (cs_fall_i)
			next_cnt = 5'h00;
		else if (sclk_rise_i && cs_low_i)
		begin
			next_shreg = {shreg[14:0], din_i};
			if (cnt != FRAME_COUNT)
				next_cnt = cnt + 5'h01;
		end
		// Only a complete frame is accepted; short frames are dropped.
		if (cs_rise_i && (cnt == FRAME_COUNT))
		begin
			next_valid = 1'b1;
			next_word  = shreg;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			shreg <= 16'h0000;
			cnt   <= 5'h00;
			valid <= 1'b0;
			word  <= 16'hffff;
		end
		else
		begin
			shreg <= next_shreg;
			cnt   <= next_cnt;
			valid <= next_valid;
			word  <= next_word;
		end
	end

	assign cmd_valid_o = valid;
	assign cmd_word_o  = word;

endmodule // aas_sin

// File: sim/aas_ctrl_model.sv
// Behavioural baseband controller that drives the 3-wire serial link.
`timescale 1ns/1ps
module aas_ctrl_model
(
	// Clock
	input  wire logic core_clk_i,
	// Device serial output
	input  wire logic dout_i,
	input  wire logic dout_oe_n_i,
	// Serial link pins
	output logic      cs_wake_n_o,
	output logic      sclk_o,
	output logic      din_o
);
	logic last_dout;
	logic dout_line;

	// Nothing pulls the line, so a released output reads as the opposite of its last level.
	assign dout_line = dout_oe_n_i ? ~last_dout : dout_i;

	always @(posedge core_clk_i)
	begin
		if (!dout_oe_n_i)
			last_dout <= dout_i;
	end

	// The serial clock rests high between frames and never runs free.
	initial
	begin
		last_dout   = 1'b0;
		cs_wake_n_o = 1'b1;
		sclk_o      = 1'b1;
		din_o       = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// One 16-bit frame with ph core cycles per clock phase; rd holds dout seen before each fall.
	task automatic frame(input logic [15:0] word, input int ph, output logic [15:0] rd);
		cs_wake_n_o = 1'b0;
		tick(ph);
		for (int i = 15; i >= 0; i--)
		begin
			rd[i]  = dout_line;
			sclk_o = 1'b0;
			din_o  = word[i];
			tick(ph);
			sclk_o = 1'b1;
			tick(ph);
		end
		cs_wake_n_o = 1'b1;
		din_o       = 1'b1;
		tick(6);
	endtask
endmodule // aas_ctrl_model

// File: sim/aas_top_bench.sv
// Self-checking bench for the aux converter serial readout block.
`timescale 1ns/1ps
module aas_top_bench
	import aas_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        cs_wake_n;
	logic        sclk;
	logic        din;
	logic        dout;
	logic        dout_oe_n;
	logic [9:0]  sample = 10'h3ff;
	logic [1:0]  input_select;
	logic        ref_sel;
	logic        convert_start;
	logic [31:0] rng = 32'h1de84b2d;
	logic [9:0]  prev;
	logic        have_result = 1'b0;
	logic [15:0] rd;
	int          err_count = 0;
	int          compares = 0;

	always #12.5 core_clk = ~core_clk;

	aas_top dut (.core_clk_i(core_clk), .srst_i(srst), .cs_wake_n_i(cs_wake_n), .sclk_i(sclk),
		.din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .sample_i(sample),
		.input_select_o(input_select), .converter_reference_select_o(ref_sel),
		.convert_start_o(convert_start));

	aas_ctrl_model ctrl (.core_clk_i(core_clk), .dout_i(dout), .dout_oe_n_i(dout_oe_n),
		.cs_wake_n_o(cs_wake_n), .sclk_o(sclk), .din_o(din));

	function automatic logic [31:0] next_rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [15:0] cmd(input logic m, input logic [2:0] dv, input logic [2:0] av,
		input logic [1:0] sl, input logic rf, input logic st);
		return {AUX_CFG_ADDR, 1'b0, m, dv, av, sl, rf, st};
	endfunction

	// Averaging codes above five saturate at thirty-two conversions.
	function automatic int conv_cycles(input logic [2:0] dv, input logic [2:0] av);
		return 12 * (1 << ((av > 3'h5) ? 5 : av)) * (1 << dv);
	endfunction

	task automatic give_verdict();
		$display("Counts: %0d compares, %0d errors", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wait_ready(output int cyc);
		cyc = 0;
		while (dout !== 1'b0 && cyc < 70000)
		begin
			ctrl.tick(1);
			cyc++;
		end
	endtask

	// Starts a conversion whose command frame also reads out the previous result.
	task automatic convert(input logic [2:0] dv, input logic [2:0] av, input int ph);
		logic [31:0] r;
		int          cyc;
		int          exp;
		r = next_rnd();
		exp = conv_cycles(dv, av);
		ctrl.frame(cmd(1'b1, dv, av, r[1:0], r[2], 1'b1), ph, rd);
		if (have_result)
			check(rd, {prev, {6{prev[0]}}}, "back-to-back readout");
		check({dout_oe_n, dout, convert_start}, 3'b011, "busy indication");
		check(input_select, r[1:0], "input select");
		check(ref_sel, r[2], "reference select");
		wait_ready(cyc);
		check((cyc + 6 >= exp) && (cyc + 6 <= exp + 12), 1'b1, "conversion time");
		check({dout_oe_n, dout, convert_start}, 3'b000, "ready indication");
		prev = sample;
		have_result = 1'b1;
		sample = r[17:8];
	endtask

	task automatic readout();
		ctrl.frame(16'hffff, 5, rd);
		check(rd, {prev, {6{prev[0]}}}, "result frame");
		check(dout_oe_n, 1'b1, "released after select");
		have_result = 1'b0;
	endtask

	initial
	begin
		repeat (40000) @(posedge core_clk);
		err_count++;
		$display("ERROR %0t: watchdog expired", $time);
		give_verdict();
	end

	initial
	begin
		int cyc;
		ctrl.tick(16);
		srst = 1'b0;
		ctrl.tick(4);
		check({dout_oe_n, dout, input_select, ref_sel, convert_start}, 6'h20, "reset");
		// Settings differ from what an all-ones frame would write, so a leak would show.
		ctrl.frame(cmd(1'b0, 3'h0, 3'h0, 2'b01, 1'b0, 1'b0), 5, rd);
		check({input_select, ref_sel, dout_oe_n}, 4'h5, "config write");
		ctrl.frame(16'hffff, 5, rd);
		check({input_select, ref_sel, dout_oe_n}, 4'h5, "void address");
		for (int d = 0; d < 8; d++)
			convert(3'(d), 3'h0, (d == 3) ? 9 : 5);
		sample = 10'h000;
		for (int a = 0; a < 8; a++)
			convert(3'h0, 3'(a), 5);
		readout();
		// Start written as zero, then as one, during a conversion has no effect.
		// This run keeps the conversion clock under the converter's limit; short dividers
		// elsewhere only keep the run brief.
		ctrl.frame(cmd(1'b1, 3'h6, 3'h0, 2'b00, 1'b0, 1'b1), 5, rd);
		ctrl.frame(cmd(1'b1, 3'h6, 3'h0, 2'b00, 1'b0, 1'b0), 5, rd);
		check({dout, convert_start}, 2'b11, "start clear ignored when busy");
		ctrl.frame(cmd(1'b1, 3'h6, 3'h0, 2'b00, 1'b0, 1'b1), 5, rd);
		check({dout, convert_start}, 2'b11, "start set ignored when busy");
		wait_ready(cyc);
		check(convert_start, 1'b0, "start self clears");
		prev = sample;
		readout();
		// Unread result in output mode zero, then a second start locks the output.
		sample = 10'(next_rnd());
		ctrl.frame(cmd(1'b0, 3'h0, 3'h0, 2'b00, 1'b0, 1'b1), 5, rd);
		wait_ready(cyc);
		ctrl.frame(16'hffff, 5, rd);
		check(rd, 16'h0000, "no data in mode zero");
		check(dout_oe_n, 1'b0, "ready held in mode zero");
		ctrl.frame(cmd(1'b0, 3'h0, 3'h0, 2'b00, 1'b0, 1'b1), 5, rd);
		ctrl.tick(60);
		check({dout_oe_n, convert_start}, 2'b10, "locked output");
		ctrl.frame(cmd(1'b1, 3'h0, 3'h0, 2'b00, 1'b0, 1'b0), 5, rd);
		check({dout_oe_n, convert_start}, 2'b10, "unlocked idle");
		convert(3'h1, 3'h1, 5);
		readout();
		give_verdict();
	end
endmodule // aas_top_bench
